// >>> hw/lcl_cluster.sv
// logic cluster of four slices with wide muxes, carry chain and distributed ram
// assumes an apb master on pclk and routing inputs synchronous to pclk
//
// Notes on behaviour
// - the cluster has four slices, each with two 4-input lookup tables feeding two registers.
// - slices 0 to 2 run logic, ripple, ram or rom mode, slice 3 never takes ram mode.
// - muxes combine lookup tables into five, six, seven and eight input functions.
// - control gives sync or async set/reset, clock select, a ram chip select and wider ram/rom.
// - each register picks clock polarity and edge or level-sensitive operation.
// - each slice takes fifteen routed inputs plus a carry input from its neighbour.
// - each slice drives six routed outputs plus a carry output.
// - in ram mode slice 2 gives the write clock from its clock and the write enable from its set/reset.
// - slice 2 gives the write bits, bits 3..2 to slice 1 and bits 1..0 to slice 0.
// - the write address is the four inputs of slice 2's first lookup table.
// - each slice shows both lookup-table results, registered one pclk late, and both register values.
// - each slice shows a five-input mux result and a six, seven or eight input result by position.
// - the eight-input function needs the neighbouring cluster through the wide mux input.
`timescale 1ns/1ps
module lcl_cluster
  import lcl_pkg::*;
#(
  parameter int NUM_SLICES = LCL_SLICES
)(
  // clock and reset
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [LCL_ADDR_W-1:0]             paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  // routing side
  input  wire logic [NUM_SLICES*LCL_ROUTE_W-1:0] slice_route_in,
  input  wire logic                              carry_chain_in,
  input  wire logic                              wide_mux_in,
  output logic      [2*NUM_SLICES-1:0]           lut_comb_out,
  output logic      [2*NUM_SLICES-1:0]           reg_out,
  output logic      [NUM_SLICES-1:0]             five_input_mux_out,
  output logic      [NUM_SLICES-1:0]             wide_mux_out,
  output logic                                   carry_chain_out
);

  if (NUM_SLICES != 4) begin : g_bad_size
    $error("cluster wiring only serves four slices");
  end

  // ==========================================================================
  // configuration storage
  logic [LCL_LUT_W-1:0] lut_q [2*NUM_SLICES];
  logic [LCL_CFG_W-1:0] cfg_q [NUM_SLICES];
  logic                 ram_cs_q;

  function automatic logic in_block(input logic [LCL_ADDR_W-1:0] a, input logic [LCL_ADDR_W-1:0] base);
    in_block = (a[LCL_ADDR_W-1:4] == base[LCL_ADDR_W-1:4]) && (a[1:0] == 2'h0);
  endfunction

  function automatic lcl_mode_e mode_of(input logic [LCL_CFG_W-1:0] c);
    mode_of = lcl_mode_e'(c[LCL_CFG_MODE +: 2]);
  endfunction

  // ==========================================================================
  // apb: setup cycle decodes, access cycle always ready
  logic       apb_setup;
  logic       apb_commit;
  logic       hit_lut;
  logic       hit_cfg;
  logic       hit_ctrl;
  logic       hit_stat;
  logic [1:0] idx;

  assign apb_setup  = psel && !penable;
  assign apb_commit = psel && penable && pready;
  assign idx        = paddr[3:2];
  assign hit_lut    = in_block(paddr, LCL_OFF_LUT);
  assign hit_cfg    = in_block(paddr, LCL_OFF_CFG);
  assign hit_ctrl   = (paddr == LCL_OFF_CTRL);
  assign hit_stat   = (paddr == LCL_OFF_STAT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup && !(hit_lut || hit_cfg || hit_ctrl || hit_stat);
      if (apb_setup && !pwrite) begin
        if (hit_lut) begin
          prdata <= {lut_q[2*idx+1], lut_q[2*idx]};
        end else if (hit_cfg) begin
          prdata <= {25'h0, cfg_q[idx]};
        end else if (hit_ctrl) begin
          prdata <= {31'h0, ram_cs_q};
        end else if (hit_stat) begin
          prdata <= {23'h0, carry_chain_out, reg_out};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  // ==========================================================================
  // slices and distributed-ram write port driven by slice 2
  logic [LCL_ROUTE_W-1:0] route [NUM_SLICES];
  logic [1:0]             comb  [NUM_SLICES];
  logic [NUM_SLICES-1:0]  five_c;
  logic [NUM_SLICES-1:0]  wide_c;
  logic [NUM_SLICES:0]    carry;
  logic [NUM_SLICES-1:0]  clk_ev;
  logic                   ram_we;
  logic [3:0]             ram_write_address;
  logic [3:0]             ram_write_bits;

  assign carry[0] = carry_chain_in;

  for (genvar s = 0; s < NUM_SLICES; s++) begin : g_slice
    assign route[s] = slice_route_in[s*LCL_ROUTE_W +: LCL_ROUTE_W];
    lcl_slice u_slice (
      .pclk            (pclk),
      .presetn         (presetn),
      .route_in        (route[s]),
      .init0           (lut_q[2*s]),
      .init1           (lut_q[2*s+1]),
      .cfg             (cfg_q[s]),
      .carry_chain_in  (carry[s]),
      .lut_comb        (comb[s]),
      .five_mux        (five_c[s]),
      .carry_chain_out (carry[s+1]),
      .clk_event       (clk_ev[s]),
      .reg_out         (reg_out[2*s +: 2])
    );
  end

  assign ram_write_address = route[2][LCL_IN_LUT0 +: 4];
  assign ram_write_bits    = route[2][LCL_IN_LUT1 +: 4];
  // write clock is slice 2's clock edge, enable is its set/reset line
  assign ram_we = ram_cs_q && (mode_of(cfg_q[2]) == LCL_MODE_RAM)
                  && clk_ev[2] && route[2][LCL_IN_LSR];

  // ==========================================================================
  // wide muxes: lut6 in slices 0 and 2, lut7 in slice 1, lut8 in slice 3
  assign wide_c[0] = route[0][LCL_IN_M1] ? five_c[1] : five_c[0];
  assign wide_c[2] = route[2][LCL_IN_M1] ? five_c[3] : five_c[2];
  assign wide_c[1] = route[1][LCL_IN_M1] ? wide_c[2] : wide_c[0];
  // lut8 takes the other cluster's lut7 as its upper half
  assign wide_c[3] = route[3][LCL_IN_M1] ? wide_mux_in : wide_c[1];

  // ==========================================================================
  // storage writes; a ram write lands after the apb write so it wins per bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2*NUM_SLICES; i++) begin
        lut_q[i] <= LCL_LUT_RST;
      end
    end else begin
      if (apb_commit && pwrite && hit_lut) begin
        lut_q[2*idx]   <= pwdata[15:0];
        lut_q[2*idx+1] <= pwdata[31:16];
      end
      for (int t = 0; t < 2; t++) begin
        if (ram_we && (mode_of(cfg_q[t]) == LCL_MODE_RAM)) begin
          lut_q[2*t][ram_write_address]   <= ram_write_bits[2*t];
          lut_q[2*t+1][ram_write_address] <= ram_write_bits[2*t+1];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_SLICES; i++) begin
        cfg_q[i] <= LCL_CFG_RST;
      end
    end else if (apb_commit && pwrite && hit_cfg) begin
      // slice 3 has no memory: a ram request falls back to logic
      if (idx == 2'h3 && pwdata[LCL_CFG_MODE +: 2] == LCL_MODE_RAM) begin
        cfg_q[idx] <= {pwdata[LCL_CFG_W-1:2], LCL_MODE_LOGIC};
      end else begin
        cfg_q[idx] <= pwdata[LCL_CFG_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_cs_q <= LCL_CS_RST;
    end else if (apb_commit && pwrite && hit_ctrl) begin
      ram_cs_q <= pwdata[0];
    end
  end

  // ==========================================================================
  // routed outputs, one pclk behind the table lookups
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lut_comb_out       <= '0;
      five_input_mux_out <= '0;
      wide_mux_out       <= '0;
      carry_chain_out    <= 1'b0;
    end else begin
      for (int s = 0; s < NUM_SLICES; s++) begin
        lut_comb_out[2*s +: 2] <= comb[s];
      end
      five_input_mux_out <= five_c;
      wide_mux_out       <= wide_c;
      carry_chain_out    <= carry[NUM_SLICES];
    end
  end

  // ==========================================================================
  // checks
  logic any_ripple;
  logic lut0_apb_wr;
  assign any_ripple  = (mode_of(cfg_q[0]) == LCL_MODE_RIPPLE) || (mode_of(cfg_q[1]) == LCL_MODE_RIPPLE)
                    || (mode_of(cfg_q[2]) == LCL_MODE_RIPPLE) || (mode_of(cfg_q[3]) == LCL_MODE_RIPPLE);
  assign lut0_apb_wr = apb_commit && pwrite && hit_lut && (idx == 2'h0);

  a_slice3_no_ram: assert property (@(posedge pclk) disable iff (!presetn)
    mode_of(cfg_q[3]) != LCL_MODE_RAM)
    else $error("slice 3 entered memory mode");
  a_ram_write_data: assert property (@(posedge pclk) disable iff (!presetn)
    ram_we && mode_of(cfg_q[0]) == LCL_MODE_RAM
    |=> lut_q[0][$past(ram_write_address)] == $past(ram_write_bits[0])
        && lut_q[1][$past(ram_write_address)] == $past(ram_write_bits[1]))
    else $error("slice 0 ram bits not written from slice 2");
  a_ram_cs_block: assert property (@(posedge pclk) disable iff (!presetn)
    !ram_cs_q && !lut0_apb_wr |=> $stable(lut_q[0]))
    else $error("ram written without chip select");
  a_five_mux_sel: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> five_input_mux_out[0] == ($past(route[0][LCL_IN_M0]) ? $past(comb[0][1]) : $past(comb[0][0])))
    else $error("five-input mux picked the wrong table");
  a_lut8_upper: assert property (@(posedge pclk) disable iff (!presetn)
    route[3][LCL_IN_M1] |=> wide_mux_out[3] == $past(wide_mux_in))
    else $error("eight-input mux ignored the neighbour cluster");
  a_carry_pass: assert property (@(posedge pclk) disable iff (!presetn)
    !any_ripple |=> carry_chain_out == $past(carry_chain_in))
    else $error("carry chain broken outside ripple mode");
  a_comb_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    mode_of(cfg_q[1]) == LCL_MODE_LOGIC ##1 mode_of(cfg_q[1]) == LCL_MODE_LOGIC
    |-> lut_comb_out[2] == lut_q[2][$past(route[1][LCL_IN_LUT0 +: 4])] || $changed(lut_q[2]))
    else $error("unregistered table output wrong");
  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    apb_setup |=> pready ##1 !pready)
    else $error("apb answer not in the access cycle");

  c_ram_write:   cover property (@(posedge pclk) disable iff (!presetn) ram_we);
  c_ripple_out:  cover property (@(posedge pclk) disable iff (!presetn) any_ripple && carry[NUM_SLICES]);
  c_lut8_select: cover property (@(posedge pclk) disable iff (!presetn) route[3][LCL_IN_M1] && wide_mux_in);

endmodule // lcl_cluster

// >>> common/lcl_pkg.sv
// constants and types of the four-slice logic cluster
// assumes one clock (pclk) and an apb slave for lookup-table and slice configuration
package lcl_pkg;

  // ==========================================================================
  // geometry
  localparam int LCL_SLICES   = 4;
  localparam int LCL_LUT_W    = 16;
  localparam int LCL_ROUTE_W  = 15;
  localparam int LCL_ADDR_W   = 12;

  // ==========================================================================
  // field positions inside one slice's routed input vector
  localparam int LCL_IN_LUT0  = 0;
  localparam int LCL_IN_LUT1  = 4;
  localparam int LCL_IN_M0    = 8;
  localparam int LCL_IN_M1    = 9;
  localparam int LCL_IN_CE    = 10;
  localparam int LCL_IN_LSR   = 11;
  localparam int LCL_IN_CLK   = 12;
  localparam int LCL_IN_DIR0  = 13;
  localparam int LCL_IN_DIR1  = 14;

  // ==========================================================================
  // slice configuration word
  localparam int LCL_CFG_W       = 7;
  localparam int LCL_CFG_MODE    = 0;
  localparam int LCL_CFG_CLK_NEG = 2;
  localparam int LCL_CFG_LATCH   = 3;
  localparam int LCL_CFG_ASYNC   = 4;
  localparam int LCL_CFG_SET     = 5;
  localparam int LCL_CFG_DIRECT  = 6;

  typedef enum logic [1:0] {
    LCL_MODE_LOGIC  = 2'h0,
    LCL_MODE_RIPPLE = 2'h1,
    LCL_MODE_RAM    = 2'h2,
    LCL_MODE_ROM    = 2'h3
  } lcl_mode_e;

  // ==========================================================================
  // register map, byte addresses
  localparam logic [11:0] LCL_OFF_LUT  = 12'h000;
  localparam logic [11:0] LCL_OFF_CFG  = 12'h010;
  localparam logic [11:0] LCL_OFF_CTRL = 12'h020;
  localparam logic [11:0] LCL_OFF_STAT = 12'h024;

  localparam logic [15:0]          LCL_LUT_RST  = 16'h0000;
  localparam logic [LCL_CFG_W-1:0] LCL_CFG_RST  = 7'h00;
  localparam logic                 LCL_CS_RST   = 1'b0;

endpackage : lcl_pkg

// >>> hw/lcl_slice.sv
// one slice: two 4-input lookup tables, ripple carry, five-input mux, two registers
// assumes lookup-table contents are held by the cluster and the routed clock is sampled on pclk
`timescale 1ns/1ps
module lcl_slice
  import lcl_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // routing and configuration
  input  wire logic [LCL_ROUTE_W-1:0] route_in,
  input  wire logic [LCL_LUT_W-1:0]   init0,
  input  wire logic [LCL_LUT_W-1:0]   init1,
  input  wire logic [LCL_CFG_W-1:0]   cfg,
  input  wire logic                   carry_chain_in,
  // results
  output logic      [1:0]             lut_comb,
  output logic                        five_mux,
  output logic                        carry_chain_out,
  output logic                        clk_event,
  output logic      [1:0]             reg_out
);

  // ==========================================================================
  // lookup tables and carry
  logic       lut0;
  logic       lut1;
  logic       ripple;
  logic       carry_mid;
  lcl_mode_e  mode;

  assign mode      = lcl_mode_e'(cfg[LCL_CFG_MODE +: 2]);
  assign ripple    = (mode == LCL_MODE_RIPPLE);
  // ram and rom reads are the same table lookup as logic mode
  assign lut0      = init0[route_in[LCL_IN_LUT0 +: 4]];
  assign lut1      = init1[route_in[LCL_IN_LUT1 +: 4]];
  // lut output is the propagate term, a/a1 input the generate term
  assign carry_mid = lut0 ? carry_chain_in : route_in[LCL_IN_LUT0];
  assign carry_chain_out = !ripple ? carry_chain_in :
                           (lut1 ? carry_mid : route_in[LCL_IN_LUT1]);
  assign lut_comb[0] = ripple ? (lut0 ^ carry_chain_in) : lut0;
  assign lut_comb[1] = ripple ? (lut1 ^ carry_mid) : lut1;
  assign five_mux    = route_in[LCL_IN_M0] ? lut_comb[1] : lut_comb[0];

  // ==========================================================================
  // register clocking emulated on pclk: polarity, edge or level
  logic       active;
  logic       active_q;
  logic       update;
  logic       local_set_reset;
  logic [1:0] reg_d;

  assign active    = route_in[LCL_IN_CLK] ^ cfg[LCL_CFG_CLK_NEG];
  assign clk_event = active & ~active_q;
  assign update    = cfg[LCL_CFG_LATCH] ? active : clk_event;
  assign local_set_reset       = route_in[LCL_IN_LSR];
  assign reg_d     = cfg[LCL_CFG_DIRECT] ? route_in[LCL_IN_DIR1:LCL_IN_DIR0] : lut_comb;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active;
    end
  end

  // async set/reset acts at the next pclk edge, no routed clock needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_out <= 2'h0;
    end else if (local_set_reset && (cfg[LCL_CFG_ASYNC] || update)) begin
      reg_out <= {2{cfg[LCL_CFG_SET]}};
    end else if (update && route_in[LCL_IN_CE]) begin
      reg_out <= reg_d;
    end
  end

  // ==========================================================================
  // checks
  a_async_lsr_force: assert property (@(posedge pclk) disable iff (!presetn)
    local_set_reset && cfg[LCL_CFG_ASYNC] |=> reg_out == {2{$past(cfg[LCL_CFG_SET])}})
    else $error("async set/reset did not force the registers");
  a_ce_low_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !route_in[LCL_IN_CE] && !local_set_reset |=> $stable(reg_out))
    else $error("registers changed with clock enable low");
  a_latch_follows: assert property (@(posedge pclk) disable iff (!presetn)
    cfg[LCL_CFG_LATCH] && active && route_in[LCL_IN_CE] && !local_set_reset
    |=> reg_out == $past(reg_d))
    else $error("transparent register did not follow the lookup tables");

endmodule // lcl_slice

// >>> bench/lcl_nbr_model.sv
// neighbour model: an adjacent cluster feeding carry and its seven-input result
// assumes pclk domain, requests set by the bench, answers after LAG cycles
`timescale 1ns/1ps
module lcl_nbr_model #(
  parameter int LAG = 2
)(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // values the neighbour should present
  input  wire logic carry_req,
  input  wire logic lut7_req,
  // wires into the cluster
  output logic      carry_o,
  output logic      lut7_o
);
  // ==========================================================================
  // delay line: lag above one models a slow neighbour
  logic [LAG-1:0] c_q;
  logic [LAG-1:0] w_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c_q <= '0;
      w_q <= '0;
    end else begin
      c_q <= LAG'({c_q, carry_req});
      w_q <= LAG'({w_q, lut7_req});
    end
  end

  assign carry_o = c_q[LAG-1];
  assign lut7_o  = w_q[LAG-1];
endmodule // lcl_nbr_model

// >>> bench/lcl_cluster_tb.sv
// self-checking bench of the four-slice logic cluster
// assumes lcl_pkg, lcl_cluster and lcl_nbr_model compiled before it
`timescale 1ns/1ps
module lcl_cluster_tb;
  import lcl_pkg::*;
  // ==========================================================================
  // signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [59:0] rt = '0;
  logic        c_req = 1'b0;
  logic        w_req = 1'b0;
  logic        c_in;
  logic        w_in;
  logic [7:0]  lco;
  logic [7:0]  rgo;
  logic [3:0]  five;
  logic [3:0]  wide;
  logic        cout;
  logic [31:0] rdv;
  logic        erv;
  logic        w0, w1, w2, w3;
  int          n_fail = 0;
  int          check_count = 0;

  typedef struct {int s; logic [3:0] a; logic [3:0] b; logic m0; logic [1:0] f; logic fv;} lcl_row_s;
  lcl_row_s rows [6] = '{'{0, 4'h0, 4'h0, 1'b0, 2'h3, 1'b1}, '{1, 4'h2, 4'hF, 1'b1, 2'h2, 1'b1},
                         '{2, 4'h9, 4'h1, 1'b0, 2'h0, 1'b0}, '{3, 4'hD, 4'h7, 1'b1, 2'h1, 1'b0},
                         '{0, 4'hF, 4'hE, 1'b1, 2'h1, 1'b0}, '{2, 4'h6, 4'h0, 1'b1, 2'h3, 1'b1}};

  always #4 pclk = ~pclk;

  lcl_cluster u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .slice_route_in(rt), .carry_chain_in(c_in), .wide_mux_in(w_in), .lut_comb_out(lco), .reg_out(rgo),
    .five_input_mux_out(five), .wide_mux_out(wide), .carry_chain_out(cout));

  lcl_nbr_model #(.LAG(2)) u_nbr (.pclk(pclk), .presetn(presetn), .carry_req(c_req), .lut7_req(w_req),
    .carry_o(c_in), .lut7_o(w_in));

  // ==========================================================================
  // helpers
  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [14:0] mk(input logic [3:0] a, input logic [3:0] b, input logic m0, input logic m1,
                                     input logic ce, input logic local_set_reset, input logic ck, input logic [1:0] dr);
    return {dr, ck, local_set_reset, ce, m1, m0, b, a};
  endfunction

  // request held until the rising edge that samples pready high; only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic step(input int s, input logic [14:0] v);
    @(posedge pclk);
    rt[15*s +: 15] <= v;
    repeat (5) @(posedge pclk);
    #1;
  endtask

  task automatic settle;
    repeat (5) @(posedge pclk);
    #1;
  endtask

  // ==========================================================================
  // watchdog, far above the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test;
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    #1;
    chk({cout, wide, five, rgo, lco}, 32'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      apb(1'b0, LCL_OFF_LUT + 12'(4*s), 32'h0);
      chk(rdv, 32'h0);
      apb(1'b0, LCL_OFF_CFG + 12'(4*s), 32'h0);
      chk(rdv, 32'h0);
      apb(1'b1, LCL_OFF_LUT + 12'(4*s), 32'h8001_A5C3);
    end
    apb(1'b0, LCL_OFF_CTRL, 32'h0);
    chk(rdv, 32'h0);
    // lookups and five-input mux per slice
    foreach (rows[i]) begin
      step(rows[i].s, mk(rows[i].a, rows[i].b, rows[i].m0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
      chk({five[rows[i].s], lco[2*rows[i].s +: 2]}, {rows[i].fv, rows[i].f});
    end
    // wide functions: slices 1 and 3 hold all ones, 0 and 2 all zeros
    for (int s = 0; s < 4; s++) apb(1'b1, LCL_OFF_LUT + 12'(4*s), (s % 2) ? 32'hFFFF_FFFF : 32'h0);
    for (int i = 0; i < 32; i++) begin
      @(posedge pclk);
      for (int s = 0; s < 4; s++) rt[15*s +: 15] <= mk(4'h0, 4'h0, 1'b0, i[s], 1'b0, 1'b0, 1'b0, 2'h0);
      w_req <= i[4];
      settle;
      w0 = i[0];
      w2 = i[2];
      w1 = i[1] ? w2 : w0;
      w3 = i[3] ? i[4] : w1;
      chk(wide, {w3, w2, w1, w0});
    end
    // slice 1 register, direct data, edge then polarity, enable, set/reset, latch
    apb(1'b1, LCL_OFF_CFG + 12'h004, 32'h40);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2));
    chk(rgo[3:2], 2'h0);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2));
    chk(rgo[3:2], 2'h2);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h1));
    chk(rgo[3:2], 2'h2);
    apb(1'b1, LCL_OFF_CFG + 12'h004, 32'h44);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h1));
    chk(rgo[3:2], 2'h1);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 2'h3));
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h3));
    chk(rgo[3:2], 2'h1);
    apb(1'b1, LCL_OFF_CFG + 12'h004, 32'h64);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0));
    chk(rgo[3:2], 2'h1);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0));
    chk(rgo[3:2], 2'h3);
    apb(1'b1, LCL_OFF_CFG + 12'h004, 32'h50);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h3));
    chk(rgo[3:2], 2'h0);
    apb(1'b1, LCL_OFF_CFG + 12'h004, 32'h48);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2));
    chk(rgo[3:2], 2'h2);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h1));
    chk(rgo[3:2], 2'h1);
    step(1, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h2));
    chk(rgo[3:2], 2'h1);
    apb(1'b0, LCL_OFF_STAT, 32'h0);
    chk(rdv & 32'hFF, 32'h04);
    // ripple: all propagate, then slice 3 generates from its lut1 input bit 0
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, LCL_OFF_CFG + 12'(4*s), {30'h0, LCL_MODE_RIPPLE});
      apb(1'b1, LCL_OFF_LUT + 12'(4*s), 32'hFFFF_FFFF);
    end
    for (int c = 1; c >= 0; c--) begin
      @(posedge pclk);
      c_req <= c[0];
      settle;
      chk({cout, lco[0]}, {c[0], ~c[0]});
    end
    apb(1'b1, LCL_OFF_LUT + 12'h00C, 32'h0000_FFFF);
    step(3, mk(4'h0, 4'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
    chk(cout, 1'b1);
    step(3, mk(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
    chk(cout, 1'b0);
    // distributed ram written from slice 2
    for (int s = 0; s < 3; s++) apb(1'b1, LCL_OFF_CFG + 12'(4*s), {30'h0, LCL_MODE_RAM});
    apb(1'b1, LCL_OFF_LUT, 32'h0);
    apb(1'b1, LCL_OFF_LUT + 12'h004, 32'h0);
    apb(1'b1, LCL_OFF_CTRL, 32'h1);
    step(2, mk(4'h5, 4'hB, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0));
    step(2, mk(4'h5, 4'hB, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0));
    step(2, mk(4'h6, 4'hF, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0));
    step(2, mk(4'h6, 4'hF, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0));
    apb(1'b1, LCL_OFF_CTRL, 32'h0);
    step(2, mk(4'h7, 4'hF, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 2'h0));
    step(2, mk(4'h7, 4'hF, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0));
    apb(1'b0, LCL_OFF_LUT, 32'h0);
    chk(rdv, 32'h0020_0020);
    apb(1'b0, LCL_OFF_LUT + 12'h004, 32'h0);
    chk(rdv, 32'h0020_0000);
    step(0, mk(4'h5, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
    chk(lco[1:0], 2'h3);
    // mode limits and refused accesses
    apb(1'b0, LCL_OFF_CFG, 32'h0);
    chk(rdv, 32'h2);
    apb(1'b1, LCL_OFF_CFG + 12'h00C, 32'h2);
    apb(1'b0, LCL_OFF_CFG + 12'h00C, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b1, LCL_OFF_CFG + 12'h00C, 32'h3);
    apb(1'b0, LCL_OFF_CFG + 12'h00C, 32'h0);
    chk(rdv, 32'h3);
    apb(1'b0, 12'h030, 32'h0);
    chk({31'h0, erv}, 32'h1);
    chk(rdv, 32'h0);
    apb(1'b1, 12'h002, 32'hFFFF_FFFF);
    chk({31'h0, erv}, 32'h1);
    apb(1'b0, LCL_OFF_LUT, 32'h0);
    chk(rdv, 32'h0020_0020);
    // reset in mid-run: tables, config and every routed output clear
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({cout, wide, five, rgo, lco}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, LCL_OFF_CFG + 12'h00C, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, LCL_OFF_LUT, 32'h0);
    chk(rdv, 32'h0);
    apb(1'b0, LCL_OFF_CTRL, 32'h0);
    chk(rdv, 32'h0);
    settle;
    chk({cout, wide, five, rgo, lco}, 32'h0);
    end_of_test;
  end
endmodule // lcl_cluster_tb
